// ---- include/adc_rr_pkg.sv ----
// Constants, register map and field layout of the round-robin ADC control block.
// Assumes a byte-wide register port and a 50 MHz system clock.
// How it works
// - Bit 0 of the event flags sets when a full 32-slot cycle completes.
// - Bit 1 sets on pen contact while biased; stays zero without a pen.
// - Bit 2 sets when the charge counter reaches half of full scale.
// - Mask bits 0..2 match the flags; one masks; masks reset to zero.
// - An unmasked set flag raises the host interrupt pin; masked flags do not.
// - Pause code 0 loops at once, 1..6 wait 4.5 ms steps, 7 never repeats.
// - Control bit 3 enables the charge counter.
// - Writing one to control bit 4 resets the charge counter.
// - The charge counter reset bit clears itself one cycle later.
// - Control bit 5 drives the pen-detect bias.
// - Bit 6 starts cycles; clearing it finishes the running cycle then stops.
// - Control bit 7 holds the converter at full power regardless of sleep.
// - Gain bits for channels 10..21 live in two registers; one means tenfold.
// - Gain bits of channels 10..13 are ignored while the touch screen is biased.
// - Each channel result splits into seven upper and three lower bits.
// - Bit 7 of the upper result reports the gain used for that conversion.
// - Each of 32 slots selects its channel in bits 4:0.
// - Slot bits 5, 6, 7 switch the X, Y and cross plate bias pairs.
package adc_rr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_SLOTS = 32;
  localparam int unsigned RES_W = 10;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h5f;
  localparam logic [7:0] ADDR_EVENT_MASKS = 8'h60;
  localparam logic [7:0] ADDR_SEQ_CTRL = 8'h61;
  localparam logic [7:0] ADDR_GAIN_LOW = 8'h62;
  localparam logic [7:0] ADDR_GAIN_HIGH = 8'h63;
  localparam logic [2:0] REGION_SLOT = 3'h4;
  localparam logic [2:0] REGION_RES_UPPER = 3'h5;
  localparam logic [2:0] REGION_RES_LOWER = 3'h6;
  localparam int unsigned EV_CYCLE = 0;
  localparam int unsigned EV_PEN = 1;
  localparam int unsigned EV_HALF = 2;
  localparam int unsigned EV_W = 3;
  localparam int unsigned CTL_CC_ON = 3;
  localparam int unsigned CTL_CC_ZERO = 4;
  localparam int unsigned CTL_PEN_BIAS = 5;
  localparam int unsigned CTL_GO = 6;
  localparam int unsigned CTL_FULL_PWR = 7;
  localparam logic [2:0] PAUSE_NONE = 3'h0;
  localparam logic [2:0] PAUSE_NO_LOOP = 3'h7;
  localparam int unsigned SLOT_X_BIAS = 5;
  localparam int unsigned SLOT_Y_BIAS = 6;
  localparam int unsigned SLOT_CROSS_BIAS = 7;
  localparam int unsigned GAIN_FIRST_CH = 10;
  localparam int unsigned GAIN_LAST_CH = 21;
  localparam int unsigned GAIN_TOUCH_LAST_CH = 13;
  localparam int unsigned GAIN_HIGH_W = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned PAUSE_STEP_US = 4500;
  localparam int unsigned PAUSE_STEP_CYC_DEF = PAUSE_STEP_US * CLK_MHZ;
  localparam int unsigned STEP_CNT_W = 21;
endpackage

// ---- hdl/adc_round_robin_control.sv ----
// Round-robin ADC sequencer with its event, control, gain, slot and result registers.
// Assumes a synchronous byte register port and a converter that answers each start with done.
`timescale 1ns/1ps
`default_nettype none
module adc_round_robin_control #(
  parameter int unsigned PAUSE_STEP_CYC = adc_rr_pkg::PAUSE_STEP_CYC_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [adc_rr_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [adc_rr_pkg::DATA_W-1:0] i_reg_wdata,
  output logic [adc_rr_pkg::DATA_W-1:0] o_reg_rdata,
  input wire logic i_pen_contact,
  input wire logic i_cc_half_scale,
  input wire logic i_conv_done,
  input wire logic [adc_rr_pkg::RES_W-1:0] i_conv_data,
  output logic o_conv_start,
  output logic [4:0] o_slot_channel_number,
  output logic o_sample_amplification_flag,
  output logic o_x_plate_bias,
  output logic o_y_plate_bias,
  output logic o_cross_plate_bias,
  output logic o_converter_full_power,
  output logic o_charge_counter_on,
  output logic o_charge_counter_zero,
  output logic o_pen_bias_on,
  output logic o_host_irq_pin
);
  import adc_rr_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_WAIT, ST_PAUSE} seq_state_t;

  localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(PAUSE_STEP_CYC - 1);
  localparam logic [4:0] SLOT_LAST = 5'(NUM_SLOTS - 1);

  logic [EV_W-1:0] flags_ff, nxt_flags;
  logic [EV_W-1:0] masks_ff, nxt_masks;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] gain_low_ff, nxt_gain_low;
  logic [GAIN_HIGH_W-1:0] gain_high_ff, nxt_gain_high;
  logic [7:0] slot_ff [NUM_SLOTS];
  logic [7:0] nxt_slot [NUM_SLOTS];
  logic [RES_W:0] res_ff [NUM_SLOTS];
  logic [RES_W:0] nxt_res [NUM_SLOTS];
  logic [7:0] rdata_ff, nxt_rdata;
  logic pen_prev_ff, half_prev_ff;
  seq_state_t state_ff, nxt_state;
  logic [4:0] slot_idx_ff, nxt_slot_idx;
  logic [STEP_CNT_W-1:0] step_cnt_ff, nxt_step_cnt;
  logic [2:0] steps_left_ff, nxt_steps_left;

  logic [NUM_SLOTS-1:0] ch_gain;
  logic touch_biased, cycle_end, pen_event, half_event, go, go_write;
  logic [7:0] cur_slot;
  logic [4:0] cur_ch;
  logic [2:0] pause_code;

  assign cur_slot = slot_ff[slot_idx_ff];
  assign cur_ch = cur_slot[4:0];
  assign go = ctrl_ff[CTL_GO];
  assign pause_code = ctrl_ff[2:0];
  assign go_write = i_reg_wr && (i_reg_addr == ADDR_SEQ_CTRL) && i_reg_wdata[CTL_GO];
  assign touch_biased = ctrl_ff[CTL_PEN_BIAS] | (|cur_slot[SLOT_CROSS_BIAS:SLOT_X_BIAS]);
  assign cycle_end = (state_ff == ST_WAIT) && i_conv_done && (slot_idx_ff == SLOT_LAST);
  assign pen_event = i_pen_contact && !pen_prev_ff && ctrl_ff[CTL_PEN_BIAS];
  assign half_event = i_cc_half_scale && !half_prev_ff;

  // Channels outside 10..21 have no gain stage and always convert at unity.
  generate
    for (genvar c = 0; c < NUM_SLOTS; c++) begin : g_gain
      if (c >= GAIN_FIRST_CH && c <= GAIN_TOUCH_LAST_CH) begin : g_touch
        assign ch_gain[c] = gain_low_ff[c - GAIN_FIRST_CH] & ~touch_biased;
      end else if (c > GAIN_TOUCH_LAST_CH && c < GAIN_FIRST_CH + 8) begin : g_low
        assign ch_gain[c] = gain_low_ff[c - GAIN_FIRST_CH];
      end else if (c >= GAIN_FIRST_CH + 8 && c <= GAIN_LAST_CH) begin : g_high
        assign ch_gain[c] = gain_high_ff[c - GAIN_FIRST_CH - 8];
      end else begin : g_unity
        assign ch_gain[c] = 1'b0;
      end
    end
  endgenerate

  // Register file. Reading the event flags clears them, but a new event in
  // the same cycle survives so no completion is lost.
  always_comb begin
    nxt_flags = flags_ff;
    if (i_reg_rd && i_reg_addr == ADDR_EVENT_FLAGS) begin
      nxt_flags = '0;
    end
    if (cycle_end) begin
      nxt_flags[EV_CYCLE] = 1'b1;
    end
    if (pen_event) begin
      nxt_flags[EV_PEN] = 1'b1;
    end
    if (half_event) begin
      nxt_flags[EV_HALF] = 1'b1;
    end
    nxt_masks = masks_ff;
    nxt_ctrl = ctrl_ff;
    nxt_ctrl[CTL_CC_ZERO] = 1'b0;
    nxt_gain_low = gain_low_ff;
    nxt_gain_high = gain_high_ff;
    nxt_slot = slot_ff;
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_EVENT_MASKS: nxt_masks = i_reg_wdata[EV_W-1:0];
        ADDR_SEQ_CTRL: nxt_ctrl = i_reg_wdata;
        ADDR_GAIN_LOW: nxt_gain_low = i_reg_wdata;
        ADDR_GAIN_HIGH: nxt_gain_high = i_reg_wdata[GAIN_HIGH_W-1:0];
        default: begin
          if (i_reg_addr[7:5] == REGION_SLOT) begin
            nxt_slot[i_reg_addr[4:0]] = i_reg_wdata;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags_ff <= '0;
      masks_ff <= '0;
      ctrl_ff <= REG_RESET;
      gain_low_ff <= REG_RESET;
      gain_high_ff <= '0;
      slot_ff <= '{default: REG_RESET};
      pen_prev_ff <= 1'b0;
      half_prev_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      masks_ff <= nxt_masks;
      ctrl_ff <= nxt_ctrl;
      gain_low_ff <= nxt_gain_low;
      gain_high_ff <= nxt_gain_high;
      slot_ff <= nxt_slot;
      pen_prev_ff <= i_pen_contact;
      half_prev_ff <= i_cc_half_scale;
    end
  end

  // Read data is registered, so it appears one cycle after the strobe.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_EVENT_FLAGS: nxt_rdata = 8'(flags_ff);
        ADDR_EVENT_MASKS: nxt_rdata = 8'(masks_ff);
        ADDR_SEQ_CTRL: nxt_rdata = ctrl_ff;
        ADDR_GAIN_LOW: nxt_rdata = gain_low_ff;
        ADDR_GAIN_HIGH: nxt_rdata = 8'(gain_high_ff);
        default: begin
          case (i_reg_addr[7:5])
            REGION_SLOT: nxt_rdata = slot_ff[i_reg_addr[4:0]];
            REGION_RES_UPPER: nxt_rdata = res_ff[i_reg_addr[4:0]][RES_W:3];
            REGION_RES_LOWER: nxt_rdata = {5'h00, res_ff[i_reg_addr[4:0]][2:0]};
            default: nxt_rdata = 8'h00;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Sequencer. The pause counts whole 4.5 ms steps; a long counter is
  // cheaper than a divider per code.
  always_comb begin
    nxt_state = state_ff;
    nxt_slot_idx = slot_idx_ff;
    nxt_step_cnt = step_cnt_ff;
    nxt_steps_left = steps_left_ff;
    nxt_res = res_ff;
    case (state_ff)
      ST_IDLE: begin
        if (go_write) begin
          nxt_state = ST_CONVERT;
          nxt_slot_idx = 5'h00;
        end
      end
      ST_CONVERT: nxt_state = ST_WAIT;
      ST_WAIT: begin
        if (i_conv_done) begin
          nxt_res[cur_ch] = {ch_gain[cur_ch], i_conv_data};
          nxt_slot_idx = slot_idx_ff + 5'h01;
          nxt_state = ST_CONVERT;
          if (slot_idx_ff == SLOT_LAST) begin
            nxt_step_cnt = '0;
            nxt_steps_left = pause_code;
            if (!go || pause_code == PAUSE_NO_LOOP) begin
              nxt_state = ST_IDLE;
            end else if (pause_code != PAUSE_NONE) begin
              nxt_state = ST_PAUSE;
            end
          end
        end
      end
      ST_PAUSE: begin
        nxt_step_cnt = step_cnt_ff + 1'b1;
        if (!go) begin
          nxt_state = ST_IDLE;
        end else if (step_cnt_ff == STEP_LAST) begin
          nxt_step_cnt = '0;
          nxt_steps_left = steps_left_ff - 3'h1;
          if (steps_left_ff == 3'h1) begin
            nxt_state = ST_CONVERT;
            nxt_slot_idx = 5'h00;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ST_IDLE;
      slot_idx_ff <= 5'h00;
      step_cnt_ff <= '0;
      steps_left_ff <= 3'h0;
      res_ff <= '{default: '0};
    end else begin
      state_ff <= nxt_state;
      slot_idx_ff <= nxt_slot_idx;
      step_cnt_ff <= nxt_step_cnt;
      steps_left_ff <= nxt_steps_left;
      res_ff <= nxt_res;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_conv_start = (state_ff == ST_CONVERT);
  assign o_slot_channel_number = cur_ch;
  assign o_sample_amplification_flag = ch_gain[cur_ch];
  assign o_x_plate_bias = cur_slot[SLOT_X_BIAS];
  assign o_y_plate_bias = cur_slot[SLOT_Y_BIAS];
  assign o_cross_plate_bias = cur_slot[SLOT_CROSS_BIAS];
  // Full power is forced by the control bit; otherwise only while converting.
  assign o_converter_full_power = ctrl_ff[CTL_FULL_PWR] |
    (state_ff == ST_CONVERT) | (state_ff == ST_WAIT);
  assign o_charge_counter_on = ctrl_ff[CTL_CC_ON];
  assign o_charge_counter_zero = ctrl_ff[CTL_CC_ZERO];
  assign o_pen_bias_on = ctrl_ff[CTL_PEN_BIAS];
  assign o_host_irq_pin = |(flags_ff & ~masks_ff);

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  irq_on_cycle_a: assert property ((cycle_end && !masks_ff[EV_CYCLE]) |=> o_host_irq_pin)
    else $error("Unmasked cycle event did not raise the interrupt.");
  irq_masked_a: assert property ((&masks_ff) |-> !o_host_irq_pin)
    else $error("Interrupt raised with all events masked.");
  cc_zero_pulse_a: assert property (o_charge_counter_zero |=> !o_charge_counter_zero)
    else $error("Charge counter reset bit did not clear itself.");
  cc_zero_write_a: assert property ((i_reg_wr && i_reg_addr == ADDR_SEQ_CTRL &&
    i_reg_wdata[CTL_CC_ZERO]) |=> o_charge_counter_zero ##1 !o_charge_counter_zero)
    else $error("Charge counter reset write did not give a one-cycle pulse.");
  cycle_flag_a: assert property (cycle_end |=> flags_ff[EV_CYCLE])
    else $error("Cycle completion flag not set.");
  half_flag_a: assert property (half_event |=> flags_ff[EV_HALF])
    else $error("Half scale flag not set.");
  pen_flag_a: assert property (pen_event |=> flags_ff[EV_PEN])
    else $error("Pen flag not set.");
  slot_order_a: assert property ((state_ff == ST_WAIT && i_conv_done && slot_idx_ff != SLOT_LAST)
    |=> slot_idx_ff == $past(slot_idx_ff) + 5'h01 && state_ff == ST_CONVERT)
    else $error("Slots not processed in ascending order.");
  touch_gain_a: assert property ((touch_biased && cur_ch >= 5'(GAIN_FIRST_CH) &&
    cur_ch <= 5'(GAIN_TOUCH_LAST_CH)) |-> !o_sample_amplification_flag)
    else $error("Gain applied to a touch channel while biased.");
  result_store_a: assert property ((state_ff == ST_WAIT && i_conv_done)
    |=> res_ff[$past(cur_ch)][RES_W-1:0] == $past(i_conv_data))
    else $error("Conversion result not stored at the selected channel.");
  full_power_a: assert property (ctrl_ff[CTL_FULL_PWR] |-> o_converter_full_power)
    else $error("Full power bit did not hold the converter awake.");
  stop_idle_a: assert property ((cycle_end && !go) |=> state_ff == ST_IDLE ##1 !o_conv_start)
    else $error("Sequencer kept running after the start bit was cleared.");
  no_loop_a: assert property ((cycle_end && pause_code == PAUSE_NO_LOOP)
    |=> state_ff == ST_IDLE)
    else $error("No-loop code did not stop the sequence.");
  loop_now_a: assert property ((cycle_end && go && pause_code == PAUSE_NONE)
    |=> o_conv_start && slot_idx_ff == 5'h00)
    else $error("Continuous loop did not restart at once.");
  // A read with no event in the same cycle must leave every flag clear.
  flag_clear_a: assert property ((i_reg_rd && i_reg_addr == ADDR_EVENT_FLAGS &&
    !cycle_end && !pen_event && !half_event) |=> flags_ff == '0)
    else $error("Reading the event flags did not clear them.");
  pause_enter_a: assert property ((cycle_end && go && pause_code != PAUSE_NONE &&
    pause_code != PAUSE_NO_LOOP) |=> state_ff == ST_PAUSE)
    else $error("Sleep code did not hold the sequencer in its pause.");
  pause_exit_a: assert property ((state_ff == ST_PAUSE && go && step_cnt_ff == STEP_LAST &&
    steps_left_ff == 3'h1) |=> o_conv_start && slot_idx_ff == 5'h00)
    else $error("Pause did not end with a start of slot 0.");
  reserved_read_a: assert property ((i_reg_rd && (i_reg_addr == ADDR_EVENT_FLAGS ||
    i_reg_addr == ADDR_EVENT_MASKS)) |=> o_reg_rdata[DATA_W-1:EV_W] == '0)
    else $error("Reserved event bits did not read as zero.");
  gain_store_a: assert property ((state_ff == ST_WAIT && i_conv_done)
    |=> res_ff[$past(cur_ch)][RES_W] == $past(o_sample_amplification_flag))
    else $error("Stored gain bit differs from the gain used.");
endmodule // adc_round_robin_control
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the round-robin ADC control block.
// Assumes the design package is compiled first; the bench plays host and converter.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adc_rr_pkg::*;
  // A short pause step keeps the seven pause codes inside a brief run.
  localparam int unsigned STEP = 20;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata;
  logic i_pen_contact = 1'b0;
  logic i_cc_half_scale = 1'b0;
  logic i_conv_done = 1'b0;
  logic [9:0] i_conv_data = 10'h000;
  logic o_conv_start, o_sample_amplification_flag, o_x_plate_bias, o_y_plate_bias;
  logic o_cross_plate_bias, o_converter_full_power, o_charge_counter_on;
  logic o_charge_counter_zero, o_pen_bias_on, o_host_irq_pin;
  logic [4:0] o_slot_channel_number;
  int error_cnt = 0;
  int samples_checked = 0;
  always #10 i_sys_clk = ~i_sys_clk;
  adc_round_robin_control #(.PAUSE_STEP_CYC(STEP)) adc_round_robin_control_inst (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_pen_contact(i_pen_contact), .i_cc_half_scale(i_cc_half_scale),
    .i_conv_done(i_conv_done), .i_conv_data(i_conv_data), .o_conv_start(o_conv_start),
    .o_slot_channel_number(o_slot_channel_number),
    .o_sample_amplification_flag(o_sample_amplification_flag),
    .o_x_plate_bias(o_x_plate_bias), .o_y_plate_bias(o_y_plate_bias),
    .o_cross_plate_bias(o_cross_plate_bias), .o_converter_full_power(o_converter_full_power),
    .o_charge_counter_on(o_charge_counter_on), .o_charge_counter_zero(o_charge_counter_zero),
    .o_pen_bias_on(o_pen_bias_on), .o_host_irq_pin(o_host_irq_pin));
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string msg);
    chk8({7'h00, got}, {7'h00, exp}, msg);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // Each access lets one edge pass first so a strobe is never re-raised in its own step.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    i_reg_wr = 1'b1; i_reg_addr = a; i_reg_wdata = d;
    tick(1);
    i_reg_wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    tick(1);
    i_reg_rd = 1'b1; i_reg_addr = a;
    tick(1);
    i_reg_rd = 1'b0;
    d = o_reg_rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    reg_rd(a, d);
    chk8(d, exp, msg);
  endtask
  function automatic logic [2:0] bias_of(input int ch);
    return (ch == 10) ? 3'h1 : (ch == 11) ? 3'h2 : (ch == 12) ? 3'h4 : 3'h0;
  endfunction
  function automatic logic gain_of(input int ch);
    return ch >= 10 && ch <= 21 && !(ch <= 13 && bias_of(ch) != 3'h0);
  endfunction
  function automatic logic [9:0] data_of(input int ch);
    return 10'(ch * 29 + 5);
  endfunction
  task automatic wait_start(output int n);
    for (n = 0; n < 400 && o_conv_start !== 1'b1; n++) tick(1);
    if (n == 400) begin
      chk1(1'b0, 1'b1, "conversion start timeout");
      conclude();
    end
  endtask
  task automatic no_start(input int cycles);
    int hits;
    hits = 0;
    repeat (cycles) begin
      if (o_conv_start === 1'b1) hits++;
      tick(1);
    end
    chk8(8'(hits), 8'h00, "start after stop");
  endtask
  // Slot s converts channel 31-s, so ascending slots fill the results from the top down.
  task automatic run_cycle(input bit mid, input logic [7:0] mid_ctl, output int gap);
    int ch, n;
    for (int s = 0; s < 32; s++) begin
      ch = 31 - s;
      wait_start(n);
      if (s == 0) gap = n;
      chk8({3'h0, o_slot_channel_number}, 8'(ch), "slot channel");
      chk8({5'h00, o_cross_plate_bias, o_y_plate_bias, o_x_plate_bias}, {5'h00, bias_of(ch)},
        "plate bias");
      chk1(o_sample_amplification_flag, gain_of(ch), "gain out");
      chk1(o_converter_full_power, 1'b1, "power while converting");
      if (mid && s == 16) reg_wr(ADDR_SEQ_CTRL, mid_ctl);
      tick(2);
      i_conv_data = data_of(ch); i_conv_done = 1'b1;
      tick(1);
      i_conv_done = 1'b0;
    end
  endtask
  task automatic t_reset_regs();
    for (int a = 8'h5f; a <= 8'h63; a++) rd_chk(8'(a), REG_RESET, "reset value");
    chk1(o_host_irq_pin, 1'b0, "irq after reset");
  endtask
  task automatic t_reserved();
    reg_wr(ADDR_EVENT_MASKS, 8'hff);
    rd_chk(ADDR_EVENT_MASKS, 8'h07, "mask reserved");
    reg_wr(ADDR_GAIN_LOW, 8'hff);
    rd_chk(ADDR_GAIN_LOW, 8'hff, "gain low");
    reg_wr(ADDR_GAIN_HIGH, 8'hff);
    rd_chk(ADDR_GAIN_HIGH, 8'h0f, "gain high reserved");
    reg_wr(ADDR_EVENT_FLAGS, 8'hff);
    rd_chk(ADDR_EVENT_FLAGS, 8'h00, "flags read only");
    rd_chk(8'h10, 8'h00, "unmapped read");
    reg_wr(ADDR_EVENT_MASKS, 8'h00);
  endtask
  task automatic t_control();
    int pulses;
    pulses = 0;
    reg_wr(ADDR_SEQ_CTRL, 8'h38);
    repeat (4) begin
      if (o_charge_counter_zero === 1'b1) pulses++;
      tick(1);
    end
    chk8(8'(pulses), 8'h01, "counter zero pulse");
    chk1(o_charge_counter_on, 1'b1, "counter on");
    chk1(o_pen_bias_on, 1'b1, "pen bias on");
    chk1(o_converter_full_power, 1'b0, "low power idle");
    rd_chk(ADDR_SEQ_CTRL, 8'h28, "zero bit self clears");
    reg_wr(ADDR_SEQ_CTRL, 8'h80);
    tick(1);
    chk1(o_converter_full_power, 1'b1, "full power");
    chk1(o_charge_counter_on, 1'b0, "counter off");
    chk1(o_pen_bias_on, 1'b0, "pen bias off");
    reg_wr(ADDR_SEQ_CTRL, 8'h00);
  endtask
  task automatic t_events();
    i_pen_contact = 1'b1;
    tick(3);
    chk1(o_host_irq_pin, 1'b0, "pen without bias");
    rd_chk(ADDR_EVENT_FLAGS, 8'h00, "no pen flag");
    i_pen_contact = 1'b0;
    reg_wr(ADDR_SEQ_CTRL, 8'h20);
    i_pen_contact = 1'b1;
    tick(2);
    chk1(o_host_irq_pin, 1'b1, "pen irq");
    rd_chk(ADDR_EVENT_FLAGS, 8'h02, "pen flag");
    chk1(o_host_irq_pin, 1'b0, "irq after clear");
    i_pen_contact = 1'b0;
    reg_wr(ADDR_EVENT_MASKS, 8'h04);
    i_cc_half_scale = 1'b1;
    tick(2);
    chk1(o_host_irq_pin, 1'b0, "masked half irq");
    rd_chk(ADDR_EVENT_FLAGS, 8'h04, "half flag");
    i_cc_half_scale = 1'b0;
    reg_wr(ADDR_EVENT_MASKS, 8'h00);
    reg_wr(ADDR_SEQ_CTRL, 8'h00);
  endtask
  task automatic t_cycle();
    int gap;
    logic [9:0] d;
    for (int s = 0; s < 32; s++) reg_wr(8'(8'h80 + s), {bias_of(31 - s), 5'(31 - s)});
    for (int s = 0; s < 32; s++)
      rd_chk(8'(8'h80 + s), {bias_of(31 - s), 5'(31 - s)}, "slot readback");
    reg_wr(ADDR_GAIN_LOW, 8'hff);
    reg_wr(ADDR_GAIN_HIGH, 8'h0f);
    reg_wr(ADDR_SEQ_CTRL, 8'h47);
    run_cycle(1'b0, 8'h00, gap);
    tick(2);
    chk1(o_host_irq_pin, 1'b1, "cycle irq");
    rd_chk(ADDR_EVENT_FLAGS, 8'h01, "cycle flag");
    no_start(3 * STEP);
    for (int ch = 0; ch < 32; ch++) begin
      d = data_of(ch);
      rd_chk(8'(8'ha0 + ch), {gain_of(ch), d[9:3]}, "result upper");
      rd_chk(8'(8'hc0 + ch), {5'h00, d[2:0]}, "result lower");
    end
  endtask
  // Clearing go in mid-cycle must still let the cycle finish before the stop.
  task automatic t_pause();
    int gap;
    for (int code = 0; code < 7; code++) begin
      reg_wr(ADDR_SEQ_CTRL, 8'(8'h40 + code));
      run_cycle(1'b0, 8'h00, gap);
      run_cycle(1'b1, 8'(code), gap);
      chk1(gap >= code * STEP && gap <= code * STEP + 4, 1'b1, "pause length");
      no_start(8 * STEP);
      rd_chk(ADDR_EVENT_FLAGS, 8'h01, "cycle flag after stop");
    end
    // Clearing go while the sequencer sleeps must cancel the next cycle.
    reg_wr(ADDR_SEQ_CTRL, 8'h41);
    run_cycle(1'b0, 8'h00, gap);
    reg_wr(ADDR_SEQ_CTRL, 8'h01);
    no_start(2 * STEP);
  endtask
  // A reset in mid-cycle must drop the sequencer and the registers at once.
  task automatic t_mid_reset();
    reg_wr(ADDR_EVENT_MASKS, 8'h07);
    reg_wr(ADDR_SEQ_CTRL, 8'hc7);
    tick(3);
    i_reset_n = 1'b0;
    tick(2);
    chk1(o_converter_full_power, 1'b0, "power in reset");
    i_reset_n = 1'b1;
    no_start(4);
    rd_chk(ADDR_EVENT_MASKS, 8'h00, "masks after reset");
    rd_chk(ADDR_SEQ_CTRL, 8'h00, "control after reset");
  endtask
  initial begin
    repeat (5) @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'b1;
    t_reset_regs();
    t_reserved();
    t_control();
    t_events();
    t_cycle();
    t_pause();
    t_mid_reset();
    conclude();
  end
endmodule // tb
`default_nettype wire
